// ### src/pfp_avalon_slave.sv
// Avalon-MM slave handshake with one wait state and registered read data
`default_nettype none
module pfp_avalon_slave #(
  parameter int DATA_W = 32
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   waitrequest,
  output logic      [DATA_W-1:0] readdata,
  output logic                   wr_stb
);
  logic              ack_q;
  logic [DATA_W-1:0] readdata_q;

  if (DATA_W < 8)
  begin : g_chk
    $error("DATA_W must be at least 8");
  end

  // One wait state gives the read mux a full cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ack_q <= 1'b0;
    else if (ack_q)
      ack_q <= 1'b0;
    else if (read || write)
      ack_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      readdata_q <= '0;
    else if (read && !ack_q)
      readdata_q <= rd_data;
  end

  assign waitrequest = (read || write) && !ack_q;
  assign wr_stb      = write && ack_q;
  assign readdata    = readdata_q;
endmodule
`default_nettype wire

// ### src/pfp_fault_protect.sv
// Fault protection of a six-output PWM unit with Avalon-MM registers
//
// How it works
// - Fault mask bits take only the first write after reset.
// - Mask bit 5 low lets debug entry raise a PWM fault.
// - Mask bit 2 low lets fault input 1 raise a PWM fault.
// - Mask bit 1 low lets the comparator raise a PWM fault.
// - Mask bit 0 low lets the fault 0 pin raise a PWM fault.
// - Unmasked comparator 0 also raises the fault exception output.
// - Masked sources never set their status flag.
// - Write one clears a flag, only once its source has dropped.
// - Status bit 7 latches each PWM reload until cleared.
// - Status bit 5 latches debug entry until cleared.
// - Status bit 2 latches comparator assertion until cleared.
// - Status bit 1 latches fault input 1 until cleared.
// - Status bit 0 latches the fault 0 pin until cleared.
// - Control bit 6 picks debug recovery: period start or soft.
// - Control bit 4 picks comparator 1 recovery: automatic or soft.
// - Control bit 2 picks comparator 0 recovery: automatic or soft.
// - Control bit 0 picks fault 0 pin recovery: automatic or soft.
// - Control bit 5 enables the comparator 1 interrupt request.
// - Control bit 3 enables the comparator 0 interrupt request.
// - Control bit 1 enables the fault 0 pin interrupt request.
// - During a fault all outputs sit in their off state.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
`include "pfp_params.svh"
module pfp_fault_protect #(
  parameter int NUM_OUT = 6
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic [1:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               fault_pin0,
  input  wire logic               fault_input1,
  input  wire logic               comparator0,
  input  wire logic               comparator1,
  input  wire logic               debug_entry,
  input  wire logic               pwm_reload,
  input  wire logic               period_start,
  input  wire logic [NUM_OUT-1:0] pwm_in,
  input  wire logic [NUM_OUT-1:0] off_state,
  output logic      [NUM_OUT-1:0] pwm_out,
  output logic                    fault_active,
  output logic                    fault_exception,
  output logic                    pin0_irq,
  output logic                    comparator0_irq,
  output logic                    comparator1_irq
);

  if (NUM_OUT < 1)
  begin : g_chk
    $error("NUM_OUT must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  pfp_pkg::pfp_byte_t      fault_source_mask_q;
  logic                    mask_locked_q;
  pfp_pkg::pfp_byte_t      fault_recovery_control_q;
  pfp_pkg::pfp_byte_t      fault_status_flags;
  logic                    dbg_prev_q;
  pfp_pkg::pfp_state_t     state_q;
  pfp_pkg::pfp_state_t     state_d;
  logic [`PFP_NUM_SRC-1:0] cause_q;
  logic [`PFP_NUM_SRC-1:0] cause_d;
  logic [`PFP_NUM_SRC-1:0] src_raw;
  logic [`PFP_NUM_SRC-1:0] src_gate;
  logic [`PFP_NUM_SRC-1:0] src_on;
  logic [`PFP_NUM_SRC-1:0] soft_sel;
  logic [`PFP_NUM_SRC-1:0] flg_set;
  logic [`PFP_NUM_SRC-1:0] flg_clr;
  logic [`PFP_NUM_SRC-1:0] flg_hold;
  logic [`PFP_NUM_SRC-1:0] flags;
  logic [NUM_OUT-1:0]      pwm_out_q;
  logic                    exception_q;
  logic                    pin0_irq_q;
  logic                    cmp0_irq_q;
  logic                    cmp1_irq_q;
  logic                    wr_stb;
  logic                    wr_mask;
  logic                    wr_status;
  logic                    wr_control;
  logic [31:0]             rd_data;
  logic                    any_on;
  logic                    flags_clear;
  logic                    soft_now;
  logic                    dbg_auto;
  logic                    exit_ok;
  logic                    dbg_rise;
  pfp_pkg::pfp_byte_t      wbyte;

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and address decode

  pfp_avalon_slave #(
    .DATA_W (32)
  ) u_slave (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .read        (avs_read),
    .write       (avs_write),
    .rd_data     (rd_data),
    .waitrequest (avs_waitrequest),
    .readdata    (avs_readdata),
    .wr_stb      (wr_stb)
  );

  assign wbyte = avs_writedata[7:0];

  always_comb
  begin
    wr_mask    = 1'b0;
    wr_status  = 1'b0;
    wr_control = 1'b0;
    if (wr_stb && avs_byteenable[0])
    begin
      if (avs_address == `PFP_IDX_MASK)
        wr_mask = 1'b1;
      else if (avs_address == `PFP_IDX_STATUS)
        wr_status = 1'b1;
      else if (avs_address == `PFP_IDX_CONTROL)
        wr_control = 1'b1;
    end
  end

  // Unmapped index reads zero, upper lanes always zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (avs_address == `PFP_IDX_MASK)
      rd_data[7:0] = fault_source_mask_q;
    else if (avs_address == `PFP_IDX_STATUS)
      rd_data[7:0] = fault_status_flags;
    else if (avs_address == `PFP_IDX_CONTROL)
      rd_data[7:0] = fault_recovery_control_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Write-once mask register and freely rewritable control register

  // A write with any value locks, so a later write cannot unmask a source
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fault_source_mask_q <= `PFP_MASK_RESET;
      mask_locked_q       <= 1'b0;
    end
    else if (wr_mask && !mask_locked_q)
    begin
      fault_source_mask_q <= wbyte & `PFP_MASK_VALID;
      mask_locked_q       <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      fault_recovery_control_q <= `PFP_CONTROL_RESET;
    else if (wr_control)
      fault_recovery_control_q <= wbyte & `PFP_CONTROL_VALID;
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault sources

  assign src_raw = {debug_entry, comparator1, comparator0,
                    fault_input1, fault_pin0};

  // Comparator 1 has no mask bit and always counts
  assign src_gate[`PFP_SRC_PIN0] = !fault_source_mask_q[`PFP_MASK_PIN0];
  assign src_gate[`PFP_SRC_IN1]  = !fault_source_mask_q[`PFP_MASK_IN1];
  assign src_gate[`PFP_SRC_CMP0] = !fault_source_mask_q[`PFP_MASK_CMP0];
  assign src_gate[`PFP_SRC_CMP1] = 1'b1;
  assign src_gate[`PFP_SRC_DBG]  = !fault_source_mask_q[`PFP_MASK_DEBUG];

  assign src_on = src_raw & src_gate;
  assign any_on = |src_on;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      dbg_prev_q <= 1'b0;
    else
      dbg_prev_q <= debug_entry;
  end

  assign dbg_rise = debug_entry && !dbg_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Status flags

  assign flg_set[`PFP_SRC_PIN0]   = src_on[`PFP_SRC_PIN0];
  assign flg_set[`PFP_SRC_IN1]    = src_on[`PFP_SRC_IN1];
  assign flg_set[`PFP_SRC_CMP0]   = src_on[`PFP_SRC_CMP0];
  assign flg_set[3]               = dbg_rise && src_gate[`PFP_SRC_DBG];
  assign flg_set[`PFP_FLG_RELOAD] = pwm_reload;

  assign flg_clr = wr_status ? {wbyte[`PFP_STAT_RELOAD],
                                wbyte[`PFP_STAT_DEBUG],
                                wbyte[`PFP_STAT_CMP0],
                                wbyte[`PFP_STAT_IN1],
                                wbyte[`PFP_STAT_PIN0]} : 5'h00;

  // Clear is refused while the raw source is still high
  assign flg_hold = {1'b0, debug_entry, comparator0,
                     fault_input1, fault_pin0};

  pfp_sticky_flags #(
    .W       (`PFP_NUM_SRC),
    .RST_VAL (`PFP_FLAGS_RESET)
  ) u_flags (
    .clk_sys (clk_sys),
    .reset   (reset),
    .set     (flg_set),
    .clr     (flg_clr),
    .hold    (flg_hold),
    .flags   (flags)
  );

  always_comb
  begin
    fault_status_flags                   = 8'h00;
    fault_status_flags[`PFP_STAT_PIN0]   = flags[`PFP_SRC_PIN0];
    fault_status_flags[`PFP_STAT_IN1]    = flags[`PFP_SRC_IN1];
    fault_status_flags[`PFP_STAT_CMP0]   = flags[`PFP_SRC_CMP0];
    fault_status_flags[`PFP_STAT_DEBUG]  = flags[3];
    fault_status_flags[`PFP_STAT_RELOAD] = flags[`PFP_FLG_RELOAD];
  end

  assign flags_clear = ~|flags[3:0];

  //////////////////////////////////////////////////////////////////////////
  // Recovery state machine

  assign soft_sel = {
    fault_recovery_control_q[`PFP_CTL_DBG_RST],
    fault_recovery_control_q[`PFP_CTL_CMP1_RST],
    fault_recovery_control_q[`PFP_CTL_CMP0_RST],
    1'b0,
    fault_recovery_control_q[`PFP_CTL_PIN0_RST]
  };

  // Any soft cause makes the whole episode soft
  assign soft_now = |(cause_q & soft_sel);
  assign dbg_auto = cause_q[`PFP_SRC_DBG] && !soft_sel[`PFP_SRC_DBG];

  always_comb
  begin
    if (soft_now)
      exit_ok = flags_clear && pwm_reload;
    else if (dbg_auto)
      exit_ok = period_start;
    else
      exit_ok = 1'b1;
  end

  always_comb
  begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      pfp_pkg::pfp_run:
      begin
        cause_d = src_on;
        if (any_on)
          state_d = pfp_pkg::pfp_hold;
      end
      pfp_pkg::pfp_hold:
      begin
        cause_d = cause_q | src_on;
        if (!any_on)
          state_d = pfp_pkg::pfp_armed;
      end
      pfp_pkg::pfp_armed:
      begin
        if (any_on)
        begin
          cause_d = cause_q | src_on;
          state_d = pfp_pkg::pfp_hold;
        end
        else if (exit_ok)
          state_d = pfp_pkg::pfp_run;
      end
      default:
        state_d = pfp_pkg::pfp_hold;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= pfp_pkg::pfp_run;
      cause_q <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Forced from the same edge that enters the fault state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pwm_out_q <= '0;
    else if (state_d != pfp_pkg::pfp_run)
      pwm_out_q <= off_state;
    else
      pwm_out_q <= pwm_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      exception_q <= 1'b0;
    else
      exception_q <= src_on[`PFP_SRC_CMP0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin0_irq_q <= 1'b0;
      cmp0_irq_q <= 1'b0;
      cmp1_irq_q <= 1'b0;
    end
    else
    begin
      pin0_irq_q <= fault_recovery_control_q[`PFP_CTL_PIN0_IRQ] &&
                    src_on[`PFP_SRC_PIN0];
      cmp0_irq_q <= fault_recovery_control_q[`PFP_CTL_CMP0_IRQ] &&
                    src_on[`PFP_SRC_CMP0];
      cmp1_irq_q <= fault_recovery_control_q[`PFP_CTL_CMP1_IRQ] &&
                    comparator1;
    end
  end

  assign pwm_out         = pwm_out_q;
  assign fault_active    = (state_q != pfp_pkg::pfp_run);
  assign fault_exception = exception_q;
  assign pin0_irq        = pin0_irq_q;
  assign comparator0_irq = cmp0_irq_q;
  assign comparator1_irq = cmp1_irq_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_armed_clean;
    state_q == pfp_pkg::pfp_armed && !any_on;
  endsequence

  sequence s_soft_go;
    s_armed_clean ##0 (soft_now && flags_clear && pwm_reload);
  endsequence

  a_mask_locked: assert property (
    (wr_mask && mask_locked_q) |=> $stable(fault_source_mask_q)
  ) else $error("mask changed after first write");

  a_mask_first: assert property (
    (wr_mask && !mask_locked_q) |=>
      fault_source_mask_q == ($past(wbyte) & `PFP_MASK_VALID)
  ) else $error("first mask write not taken");

  a_debug_raise: assert property (
    (debug_entry && !fault_source_mask_q[`PFP_MASK_DEBUG]) |=> fault_active
  ) else $error("debug entry did not raise fault");

  a_input1_raise: assert property (
    (fault_input1 && !fault_source_mask_q[`PFP_MASK_IN1]) |=> fault_active
  ) else $error("fault input 1 did not raise fault");

  a_cmp_raise: assert property (
    (comparator0 && !fault_source_mask_q[`PFP_MASK_CMP0]) |=>
      (fault_active && fault_exception)
  ) else $error("comparator did not raise fault");

  a_pin0_raise: assert property (
    (fault_pin0 && !fault_source_mask_q[`PFP_MASK_PIN0]) |=> fault_active
  ) else $error("fault pin 0 did not raise fault");

  a_exc_follow: assert property (
    fault_exception == $past(comparator0 &&
                             !fault_source_mask_q[`PFP_MASK_CMP0])
  ) else $error("fault exception mismatch");

  a_masked_quiet: assert property (
    (fault_source_mask_q[`PFP_MASK_PIN0] && !flags[`PFP_SRC_PIN0])
      |=> !flags[`PFP_SRC_PIN0]
  ) else $error("masked pin 0 set its flag");

  a_clear_refused: assert property (
    (wr_status && wbyte[`PFP_STAT_CMP0] && comparator0 &&
     flags[`PFP_SRC_CMP0]) |=> flags[`PFP_SRC_CMP0]
  ) else $error("flag cleared while source high");

  a_clear_taken: assert property (
    (wr_status && wbyte[`PFP_STAT_PIN0] && !fault_pin0) |=>
      !flags[`PFP_SRC_PIN0]
  ) else $error("write one did not clear flag");

  a_reload_flag: assert property (
    pwm_reload |=> flags[`PFP_FLG_RELOAD] [*2] or
      (flags[`PFP_FLG_RELOAD] ##1 $past(wr_status))
  ) else $error("reload flag not latched");

  a_debug_flag: assert property (
    (dbg_rise && !fault_source_mask_q[`PFP_MASK_DEBUG]) |=> flags[3]
  ) else $error("debug flag not set");

  a_soft_exit: assert property (
    s_soft_go |=> state_q == pfp_pkg::pfp_run
  ) else $error("soft recovery did not release");

  a_soft_block: assert property (
    (s_armed_clean ##0 (soft_now && !flags_clear)) |=>
      state_q != pfp_pkg::pfp_run
  ) else $error("released with flags pending");

  a_auto_exit: assert property (
    (s_armed_clean ##0 (!soft_now && !dbg_auto)) |=>
      state_q == pfp_pkg::pfp_run
  ) else $error("automatic recovery stuck");

  a_dbg_period: assert property (
    (s_armed_clean ##0 (!soft_now && dbg_auto && !period_start)) |=>
      state_q != pfp_pkg::pfp_run
  ) else $error("debug recovery before period start");

  a_irq_gate: assert property (
    {comparator1_irq, comparator0_irq, pin0_irq} ==
      $past({fault_recovery_control_q[`PFP_CTL_CMP1_IRQ] && comparator1,
             fault_recovery_control_q[`PFP_CTL_CMP0_IRQ] &&
               src_on[`PFP_SRC_CMP0],
             fault_recovery_control_q[`PFP_CTL_PIN0_IRQ] &&
               src_on[`PFP_SRC_PIN0]})
  ) else $error("interrupt request mismatch");

  a_force_off: assert property (
    fault_active |-> pwm_out == $past(off_state)
  ) else $error("outputs not forced off");

  a_reserved_zero: assert property (
    avs_readdata[31:8] == 24'h00_0000 &&
    (fault_recovery_control_q & ~`PFP_CONTROL_VALID) == 8'h00
  ) else $error("reserved bits not zero");

endmodule
`default_nettype wire

// ### src/pfp_params.svh
// Register offsets, field positions and reset values of the fault block
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH

// Word indices on the Avalon address (byte address is four times these)
`define PFP_IDX_MASK       2'h0
`define PFP_IDX_STATUS     2'h1
`define PFP_IDX_CONTROL    2'h2

// Reset values
`define PFP_MASK_RESET     8'h00
`define PFP_CONTROL_RESET  8'h00
`define PFP_FLAGS_RESET    5'h00

// Implemented bits of each register; all others read zero
`define PFP_MASK_VALID     8'h27
`define PFP_STATUS_VALID   8'hA7
`define PFP_CONTROL_VALID  8'h7F

// Mask register fields
`define PFP_MASK_PIN0      0
`define PFP_MASK_CMP0      1
`define PFP_MASK_IN1       2
`define PFP_MASK_DEBUG     5

// Status register fields
`define PFP_STAT_PIN0      0
`define PFP_STAT_IN1       1
`define PFP_STAT_CMP0      2
`define PFP_STAT_DEBUG     5
`define PFP_STAT_RELOAD    7

// Control register fields
`define PFP_CTL_PIN0_RST   0
`define PFP_CTL_PIN0_IRQ   1
`define PFP_CTL_CMP0_RST   2
`define PFP_CTL_CMP0_IRQ   3
`define PFP_CTL_CMP1_RST   4
`define PFP_CTL_CMP1_IRQ   5
`define PFP_CTL_DBG_RST    6

// Fault source vector and sticky flag vector positions
`define PFP_NUM_SRC        5
`define PFP_SRC_PIN0       0
`define PFP_SRC_IN1        1
`define PFP_SRC_CMP0       2
`define PFP_SRC_CMP1       3
`define PFP_SRC_DBG        4
`define PFP_FLG_RELOAD     4

`endif

// ### src/pfp_pkg.sv
// Types shared by the fault protection block
`default_nettype none
package pfp_pkg;
  typedef enum logic [1:0] {
    pfp_run   = 2'b00,
    pfp_hold  = 2'b01,
    pfp_armed = 2'b10
  } pfp_state_t;
  typedef logic [7:0] pfp_byte_t;
endpackage
`default_nettype wire

// ### src/pfp_sticky_flags.sv
// Sticky flags: set wins, write-one clear blocked while the source holds
`default_nettype none
module pfp_sticky_flags #(
  parameter int            W       = 5,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] hold,
  output logic      [W-1:0] flags
);
  logic [W-1:0] flags_q;

  if (W < 1)
  begin : g_chk
    $error("W must be at least 1");
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flags_q <= RST_VAL;
    else
      flags_q <= (flags_q & ~(clr & ~hold)) | set;
  end

  assign flags = flags_q;
endmodule
`default_nettype wire

// ### tb/pfp_src_model.sv
// Behavioural model of the fault sources and PWM timing pulses
`default_nettype none
module pfp_src_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [4:0] lvl,
  input  wire logic       rld_req,
  input  wire logic       per_req,
  output logic            fault_pin0,
  output logic            fault_input1,
  output logic            comparator0,
  output logic            comparator1,
  output logic            debug_entry,
  output logic            pwm_reload,
  output logic            period_start
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] src_q;
  ////////////////////////////////////////////////////////////////////////////
  // Levels move on the clock, as synchronised pins would
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      src_q <= 5'h00;
    else
      src_q <= lvl;
  end
  // Timer pulses last exactly one cycle
  always_ff @(posedge clk_sys)
  begin
    pwm_reload   <= rld_req & ~reset;
    period_start <= per_req & ~reset;
  end
  assign fault_pin0   = src_q[0];
  assign fault_input1 = src_q[1];
  assign comparator0  = src_q[2];
  assign comparator1  = src_q[3];
  assign debug_entry  = src_q[4];
endmodule
`default_nettype wire

// ### tb/test_pfp_fault_protect.sv
// Register and fault path test of the fault protection block
`default_nettype none
module test_pfp_fault_protect;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  lvl = 5'h00;
  logic        rld_req = 1'b0;
  logic        per_req = 1'b0;
  logic        fault_pin0, fault_input1, comparator0, comparator1;
  logic        debug_entry, pwm_reload, period_start, fault_active;
  logic        fault_exception, pin0_irq, comparator0_irq, comparator1_irq;
  logic [5:0]  pwm_out;
  int          n_errors = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  pfp_fault_protect u_pfp_fault_protect (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fault_pin0(fault_pin0), .fault_input1(fault_input1),
    .comparator0(comparator0), .comparator1(comparator1),
    .debug_entry(debug_entry), .pwm_reload(pwm_reload),
    .period_start(period_start), .pwm_in(6'h2A), .off_state(6'h15),
    .pwm_out(pwm_out), .fault_active(fault_active),
    .fault_exception(fault_exception), .pin0_irq(pin0_irq),
    .comparator0_irq(comparator0_irq), .comparator1_irq(comparator1_irq));
  pfp_src_model u_pfp_src_model (
    .clk_sys(clk_sys), .reset(reset), .lvl(lvl), .rld_req(rld_req),
    .per_req(per_req), .fault_pin0(fault_pin0),
    .fault_input1(fault_input1), .comparator0(comparator0),
    .comparator1(comparator1), .debug_entry(debug_entry),
    .pwm_reload(pwm_reload), .period_start(period_start));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    begin
      $display("checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_errors++;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Entered just after a rising edge; an idle edge follows each transfer
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    begin
      n = 0;
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= wr;
      avs_read      <= ~wr;
      do
      begin
        @(posedge clk_sys);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
      if (n >= 20)
      begin
        n_errors++;
        final_report();
      end
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    begin
      bus(1'b1, a, d, q);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    logic [31:0] q;
    begin
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h000000, e});
    end
  endtask
  // Irq order: exception, pin 0, comparator 0, comparator 1
  task automatic obs(input logic act, input logic [3:0] irq);
    begin
      @(negedge clk_sys);
      chk({25'h0, fault_active, pwm_out}, {25'h0, act, act ? 6'h15 : 6'h2A});
      chk({28'h0, fault_exception, pin0_irq, comparator0_irq,
           comparator1_irq}, {28'h0, irq});
      @(posedge clk_sys);
    end
  endtask
  // Source bits: pin 0, input 1, comparator 0, comparator 1, debug
  task automatic src(input logic [4:0] v, input int n);
    begin
      lvl <= v;
      repeat (n) @(posedge clk_sys);
    end
  endtask
  task automatic pulse(input logic reload);
    begin
      rld_req <= reload;
      per_req <= ~reload;
      @(posedge clk_sys);
      rld_req <= 1'b0;
      per_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    obs(1'b0, 4'h0);
    wr(2'h2, 8'h7F);
    rd(2'h2, 8'h7F);
    $display("test registers done");
    wr(2'h2, 8'h02);
    src(5'h01, 3);
    rd(2'h1, 8'h01);
    obs(1'b1, 4'h4);
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h01);
    src(5'h00, 5);
    obs(1'b0, 4'h0);
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h00);
    $display("test pin0 done");
    wr(2'h2, 8'h0C);
    src(5'h04, 3);
    rd(2'h1, 8'h04);
    obs(1'b1, 4'hA);
    wr(2'h1, 8'h04);
    rd(2'h1, 8'h04);
    src(5'h00, 5);
    obs(1'b1, 4'h0);
    wr(2'h1, 8'h04);
    obs(1'b1, 4'h0);
    pulse(1'b1);
    obs(1'b0, 4'h0);
    rd(2'h1, 8'h80);
    wr(2'h1, 8'h80);
    rd(2'h1, 8'h00);
    $display("test comparator0 done");
    wr(2'h2, 8'h01);
    src(5'h03, 3);
    rd(2'h1, 8'h03);
    obs(1'b1, 4'h0);
    src(5'h00, 5);
    obs(1'b1, 4'h0);
    wr(2'h1, 8'h03);
    pulse(1'b1);
    obs(1'b0, 4'h0);
    wr(2'h1, 8'h80);
    $display("test input1 done");
    wr(2'h2, 8'h30);
    src(5'h08, 3);
    obs(1'b1, 4'h1);
    src(5'h00, 5);
    obs(1'b1, 4'h0);
    pulse(1'b1);
    obs(1'b0, 4'h0);
    wr(2'h1, 8'h80);
    $display("test comparator1 done");
    wr(2'h2, 8'h00);
    src(5'h10, 3);
    rd(2'h1, 8'h20);
    obs(1'b1, 4'h0);
    src(5'h00, 5);
    obs(1'b1, 4'h0);
    pulse(1'b0);
    obs(1'b0, 4'h0);
    wr(2'h1, 8'h20);
    rd(2'h1, 8'h00);
    $display("test debug done");
    wr(2'h0, 8'h27);
    rd(2'h0, 8'h27);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h27);
    src(5'h17, 3);
    rd(2'h1, 8'h00);
    obs(1'b0, 4'h0);
    src(5'h00, 3);
    $display("test mask done");
    final_report();
  end
endmodule
`default_nettype wire
